// [tpt_params.svh]
// constants for the tape reader, punch and tick interfaces
`ifndef TPT_PARAMS_SVH
`define TPT_PARAMS_SVH
// register byte addresses on the serial bus
`define TPT_ADDR_TICK_STATUS 16'hffe6
`define TPT_ADDR_RDR_STATUS 16'hffe8
`define TPT_ADDR_RDR_DATA 16'hffea
`define TPT_ADDR_PUN_STATUS 16'hffec
`define TPT_ADDR_PUN_DATA 16'hffee
// status bit positions, shared by all three status registers
`define TPT_BIT_DONE 7
`define TPT_BIT_IE 6
// reader status: load flag
`define TPT_BIT_LOAD 0
// punch status: unit not available and error
`define TPT_BIT_NA 0
`define TPT_BIT_ERR 1
// tick status: rate select field
`define TPT_RATE_LO 1
`define TPT_RATE_HI 2
// transfer vector addresses
`define TPT_VEC_RDR 8'he8
`define TPT_VEC_TICK 8'hec
`define TPT_VEC_PUN 8'hf0
`define TPT_VEC_NONE 8'h00
// reset values
`define TPT_RST_STATUS 8'h00
`define TPT_RST_RATE 2'h0
// tick rates in hertz and the cycle counts they give at the system clock
`define TPT_CLK_HZ 50000000
`define TPT_TICK_HZ_1000 1000
`define TPT_TICK_HZ_200 200
`define TPT_TICK_HZ_100 100
`define TPT_TICK_HZ_20 20
`define TPT_CYC_1000 (`TPT_CLK_HZ / `TPT_TICK_HZ_1000)
`define TPT_CYC_200 (`TPT_CLK_HZ / `TPT_TICK_HZ_200)
`define TPT_CYC_100 (`TPT_CLK_HZ / `TPT_TICK_HZ_100)
`define TPT_CYC_20 (`TPT_CLK_HZ / `TPT_TICK_HZ_20)
`endif

// [tpt_pkg.sv]
// types for the tape reader, punch and tick interfaces
package tpt_pkg;
  // one byte access from the serial bus
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } tpt_bus_req_t;
  // mechanism pins, all asynchronous to sys_clk
  typedef struct packed {
    logic [7:0] rdr_char;
    logic rdr_strobe;
    logic load_sw;
    logic pun_end;
    logic pun_na;
    logic pun_err;
    logic pun_load_pos;
  } tpt_mech_in_t;
  // reader sequencer, gray coded except the wait to idle step
  typedef enum logic [1:0] {
    TPT_RD_IDLE = 2'b00,
    TPT_RD_ADV = 2'b01,
    TPT_RD_WAIT = 2'b11
  } tpt_rd_state_t;
endpackage

// [tpt_ifc.sv]
// tape reader, tape punch and periodic tick interfaces on the serial bus
// Summary of operation
// - buffer read clears done, advances tape
// - done set when new character captured
// - load switch high blocks advance, sets load
// - load low: clear load, fill, set done
// - load rise clears done; no done meanwhile
// - enabled done or load rise requests interrupt
// - reader status read clears its request
// - punch write starts cycle, done after end
// - not available or error drops the write
// - enabled done, error, na rise interrupts
// - punch status read clears its request
// - punch load position reports tape error
// - tick rate selectable among four frequencies
// - tick done once per period, interrupt
// - tick status read clears request and done
// - punch registers at fixed byte addresses
// - punch vectors to location two forty
// - reader fixed addresses, vector two thirty-two
// - reader polls above the punch
`include "tpt_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tpt_ifc #(
  parameter int unsigned CYC_1000 = `TPT_CYC_1000,
  parameter int unsigned CYC_200 = `TPT_CYC_200,
  parameter int unsigned CYC_100 = `TPT_CYC_100,
  parameter int unsigned CYC_20 = `TPT_CYC_20,
  parameter int unsigned CNT_W = 22
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire tpt_pkg::tpt_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  output logic bus_rvalid,
  input wire tpt_pkg::tpt_mech_in_t mech_in,
  output logic rdr_advance,
  output logic pun_start,
  output logic [7:0] pun_char,
  output logic rdr_irq,
  output logic pun_irq,
  output logic tick_irq,
  output logic irq_any,
  output logic [7:0] irq_vector
);

  localparam int unsigned MW = $bits(tpt_pkg::tpt_mech_in_t);

  // two-stage synchroniser for every mechanism pin
  logic [MW-1:0] sync1_r; // first stage, read only by the second
  logic [MW-1:0] sync2_r; // safe copy of the pins
  tpt_pkg::tpt_mech_in_t pins; // named view of the safe copy
  logic rdr_strobe_d_r; // delayed strobes and levels for edges
  logic load_d_r;
  logic pun_end_d_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= mech_in;
      sync2_r <= sync1_r;
    end
  end

  assign pins = tpt_pkg::tpt_mech_in_t'(sync2_r);

  // edge history for the synchronised levels
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdr_strobe_d_r <= 1'b0;
      load_d_r <= 1'b0;
      pun_end_d_r <= 1'b0;
    end else begin
      rdr_strobe_d_r <= pins.rdr_strobe;
      load_d_r <= pins.load_sw;
      pun_end_d_r <= pins.pun_end;
    end
  end

  logic rdr_char_ev; // reader presents a new character
  logic load_rise; // load switch raised
  logic load_fall; // load switch lowered
  logic pun_end_ev; // punch finished its cycle

  assign rdr_char_ev = pins.rdr_strobe & ~rdr_strobe_d_r;
  assign load_rise = pins.load_sw & ~load_d_r;
  assign load_fall = ~pins.load_sw & load_d_r;
  assign pun_end_ev = pins.pun_end & ~pun_end_d_r;

  // address decode, byte accesses only
  logic rd_tick_st;
  logic rd_rdr_st;
  logic rd_rdr_data;
  logic rd_pun_st;
  logic wr_tick_st;
  logic wr_rdr_st;
  logic wr_pun_st;
  logic wr_pun_data;

  assign rd_tick_st = bus_req.rd && bus_req.addr == `TPT_ADDR_TICK_STATUS;
  assign rd_rdr_st = bus_req.rd && bus_req.addr == `TPT_ADDR_RDR_STATUS;
  assign rd_rdr_data = bus_req.rd && bus_req.addr == `TPT_ADDR_RDR_DATA;
  assign rd_pun_st = bus_req.rd && bus_req.addr == `TPT_ADDR_PUN_STATUS;
  assign wr_tick_st = bus_req.wr && bus_req.addr == `TPT_ADDR_TICK_STATUS;
  assign wr_rdr_st = bus_req.wr && bus_req.addr == `TPT_ADDR_RDR_STATUS;
  assign wr_pun_st = bus_req.wr && bus_req.addr == `TPT_ADDR_PUN_STATUS;
  assign wr_pun_data = bus_req.wr && bus_req.addr == `TPT_ADDR_PUN_DATA;

  // ---------------- reader ----------------
  tpt_pkg::tpt_rd_state_t rd_state_r; // advance sequencer
  logic [7:0] rdr_buf_r; // last captured character
  logic rdr_done_r;
  logic rdr_load_r;
  logic rdr_ie_r;
  logic rdr_done_d_r; // flag history for rising edges
  logic rdr_load_d_r;
  logic rdr_pend_r; // internal request before the poll register

  // advance sequencer: one advance pulse, then wait for the character
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_state_r <= tpt_pkg::TPT_RD_IDLE;
    end else begin
      unique case (rd_state_r)
        tpt_pkg::TPT_RD_IDLE: begin
          // a buffer read advances unless loading
          if (rd_rdr_data && !pins.load_sw) begin
            rd_state_r <= tpt_pkg::TPT_RD_ADV;
          end else if (load_fall) begin
            rd_state_r <= tpt_pkg::TPT_RD_ADV;
          end
        end
        tpt_pkg::TPT_RD_ADV: begin
          rd_state_r <= tpt_pkg::TPT_RD_WAIT;
        end
        tpt_pkg::TPT_RD_WAIT: begin
          // raising load abandons the pending character
          if (pins.load_sw) begin
            rd_state_r <= tpt_pkg::TPT_RD_IDLE;
          end else if (rdr_char_ev) begin
            rd_state_r <= tpt_pkg::TPT_RD_IDLE;
          end
        end
      endcase
    end
  end

  // advance pulse to the tape mechanism, straight from a flop
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdr_advance <= 1'b0;
    end else begin
      rdr_advance <= rd_state_r == tpt_pkg::TPT_RD_ADV;
    end
  end

  // character capture only while a fetch is outstanding
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdr_buf_r <= 8'h00;
    end else if (rd_state_r == tpt_pkg::TPT_RD_WAIT && rdr_char_ev && !pins.load_sw) begin
      rdr_buf_r <= pins.rdr_char;
    end
  end

  // done flag; load wins over everything, capture wins over the read clear
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdr_done_r <= 1'b0;
    end else if (pins.load_sw) begin
      rdr_done_r <= 1'b0;
    end else if (rd_state_r == tpt_pkg::TPT_RD_WAIT && rdr_char_ev) begin
      rdr_done_r <= 1'b1;
    end else if (rd_rdr_data) begin
      rdr_done_r <= 1'b0;
    end
  end

  // load flag follows the synchronised switch
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdr_load_r <= 1'b0;
    end else begin
      rdr_load_r <= pins.load_sw;
    end
  end

  // software interrupt enable
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdr_ie_r <= 1'b0;
    end else if (wr_rdr_st) begin
      rdr_ie_r <= bus_req.wdata[`TPT_BIT_IE];
    end
  end

  // request on a rising done or load; set wins over the status read
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdr_done_d_r <= 1'b0;
      rdr_load_d_r <= 1'b0;
      rdr_pend_r <= 1'b0;
    end else begin
      rdr_done_d_r <= rdr_done_r;
      rdr_load_d_r <= rdr_load_r;
      if (rdr_ie_r && ((rdr_done_r && !rdr_done_d_r) || (rdr_load_r && !rdr_load_d_r))) begin
        rdr_pend_r <= 1'b1;
      end else if (rd_rdr_st) begin
        rdr_pend_r <= 1'b0;
      end
    end
  end

  // ---------------- punch ----------------
  logic pun_done_r;
  logic pun_na_r;
  logic pun_err_r;
  logic pun_ie_r;
  logic pun_busy_r; // a cycle is under way
  logic pun_flags_d_r; // history for the three flags
  logic pun_na_d_r;
  logic pun_err_d_r;
  logic pun_pend_r;
  logic pun_ok; // unit can accept a character

  assign pun_ok = !pun_na_r && !pun_err_r;

  // status flags from the unit; load position shows as tape error
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pun_na_r <= 1'b0;
      pun_err_r <= 1'b0;
    end else begin
      pun_na_r <= pins.pun_na;
      pun_err_r <= pins.pun_err | pins.pun_load_pos;
    end
  end

  // a write when the unit is fit and not busy latches the byte and starts a cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pun_char <= 8'h00;
      pun_start <= 1'b0;
    end else begin
      pun_start <= wr_pun_data && pun_ok && !pun_busy_r;
      if (wr_pun_data && pun_ok && !pun_busy_r) begin
        pun_char <= bus_req.wdata;
      end
    end
  end

  // busy from the start until the unit reports the end of the cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pun_busy_r <= 1'b0;
    end else if (pun_start) begin
      pun_busy_r <= 1'b1;
    end else if (pun_end_ev || !pun_ok) begin
      pun_busy_r <= 1'b0; // a failed unit abandons the cycle
    end
  end

  // done: ready after reset, cleared by an accepted write, inhibited on fault
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pun_done_r <= 1'b1;
    end else if (!pun_ok) begin
      pun_done_r <= 1'b0;
    end else if (wr_pun_data && !pun_busy_r) begin
      pun_done_r <= 1'b0;
    end else if (pun_busy_r && pun_end_ev) begin
      pun_done_r <= 1'b1;
    end
  end

  // software interrupt enable
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pun_ie_r <= 1'b0;
    end else if (wr_pun_st) begin
      pun_ie_r <= bus_req.wdata[`TPT_BIT_IE];
    end
  end

  // request on any flag going to one; set wins over the status read
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pun_flags_d_r <= 1'b1;
      pun_na_d_r <= 1'b0;
      pun_err_d_r <= 1'b0;
      pun_pend_r <= 1'b0;
    end else begin
      pun_flags_d_r <= pun_done_r;
      pun_na_d_r <= pun_na_r;
      pun_err_d_r <= pun_err_r;
      if (pun_ie_r && ((pun_done_r && !pun_flags_d_r) || (pun_na_r && !pun_na_d_r)
          || (pun_err_r && !pun_err_d_r))) begin
        pun_pend_r <= 1'b1;
      end else if (rd_pun_st) begin
        pun_pend_r <= 1'b0;
      end
    end
  end

  // ---------------- tick ----------------
  logic [1:0] tick_rate_r; // 3:1000 2:200 1:100 0:20 hertz
  logic tick_ie_r;
  logic tick_done_r;
  logic tick_pend_r;
  logic [CNT_W-1:0] tick_cnt_r;
  logic [CNT_W-1:0] tick_last; // terminal count of the period
  logic tick_ev;

  // period length per rate code
  always_comb begin
    unique case (tick_rate_r)
      2'h3: tick_last = CNT_W'(CYC_1000 - 1);
      2'h2: tick_last = CNT_W'(CYC_200 - 1);
      2'h1: tick_last = CNT_W'(CYC_100 - 1);
      2'h0: tick_last = CNT_W'(CYC_20 - 1);
    endcase
  end

  assign tick_ev = tick_cnt_r >= tick_last;

  // rate and enable from software; a write restarts the period
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tick_rate_r <= `TPT_RST_RATE;
      tick_ie_r <= 1'b0;
    end else if (wr_tick_st) begin
      tick_rate_r <= bus_req.wdata[`TPT_RATE_HI:`TPT_RATE_LO];
      tick_ie_r <= bus_req.wdata[`TPT_BIT_IE];
    end
  end

  // free running period counter
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_r <= '0;
    end else if (wr_tick_st || tick_ev) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end

  // done and request; a tick in the read cycle is kept
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tick_done_r <= 1'b0;
      tick_pend_r <= 1'b0;
    end else begin
      if (tick_ev) begin
        tick_done_r <= 1'b1;
      end else if (rd_tick_st) begin
        tick_done_r <= 1'b0;
      end
      if (tick_ev && tick_ie_r) begin
        tick_pend_r <= 1'b1;
      end else if (rd_tick_st) begin
        tick_pend_r <= 1'b0;
      end
    end
  end

  // ---------------- bus read and poll ----------------
  // read data registered one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bus_rdata <= `TPT_RST_STATUS;
      bus_rvalid <= 1'b0;
    end else begin
      bus_rvalid <= bus_req.rd;
      bus_rdata <= `TPT_RST_STATUS;
      if (rd_tick_st) begin
        bus_rdata <= {tick_done_r, tick_ie_r, 3'h0, tick_rate_r, 1'b0};
      end else if (rd_rdr_st) begin
        bus_rdata <= {rdr_done_r, rdr_ie_r, 5'h00, rdr_load_r};
      end else if (rd_rdr_data) begin
        bus_rdata <= rdr_buf_r;
      end else if (rd_pun_st) begin
        bus_rdata <= {pun_done_r, pun_ie_r, 4'h0, pun_err_r, pun_na_r};
      end
    end
  end

  // poll outputs; tick, then reader, then punch by poll position
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdr_irq <= 1'b0;
      pun_irq <= 1'b0;
      tick_irq <= 1'b0;
      irq_any <= 1'b0;
      irq_vector <= `TPT_VEC_NONE;
    end else begin
      rdr_irq <= rdr_pend_r;
      pun_irq <= pun_pend_r;
      tick_irq <= tick_pend_r;
      irq_any <= rdr_pend_r | pun_pend_r | tick_pend_r;
      if (tick_pend_r) begin
        irq_vector <= `TPT_VEC_TICK;
      end else if (rdr_pend_r) begin
        irq_vector <= `TPT_VEC_RDR;
      end else if (pun_pend_r) begin
        irq_vector <= `TPT_VEC_PUN;
      end else begin
        irq_vector <= `TPT_VEC_NONE;
      end
    end
  end

endmodule
`default_nettype wire

// [tpt_ifc_sva.sv]
// port assertions for the tape reader, punch and tick interfaces
`timescale 1ns/1ps
`default_nettype none
`include "tpt_params.svh"
module tpt_ifc_sva (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire tpt_pkg::tpt_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic bus_rvalid,
  input wire tpt_pkg::tpt_mech_in_t mech_in,
  input wire logic rdr_advance,
  input wire logic pun_start,
  input wire logic [7:0] pun_char,
  input wire logic rdr_irq,
  input wire logic pun_irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // decoded places; write-only punch data counted so its read is not judged
  logic mapped;
  // address decode of the five byte registers
  always_comb begin
    mapped = bus_req.addr inside {`TPT_ADDR_TICK_STATUS, `TPT_ADDR_RDR_STATUS,
      `TPT_ADDR_RDR_DATA, `TPT_ADDR_PUN_STATUS, `TPT_ADDR_PUN_DATA};
  end
  a_read_answers: assert property (bus_req.rd |=> bus_rvalid)
    else $error("read got no valid");
  a_valid_cause: assert property (bus_rvalid |-> $past(bus_req.rd))
    else $error("valid without read");
  a_unmapped_zero: assert property (bus_req.rd && !mapped |=> bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  // six cycles covers the synchroniser and a fetch already in flight
  a_load_blocks: assert property (mech_in.load_sw [*6] |-> !rdr_advance)
    else $error("advance while load held");
  a_adv_single: assert property (rdr_advance |=> !rdr_advance)
    else $error("advance longer than one cycle");
  a_start_cause: assert property (pun_start |-> $past(bus_req.wr)
      && $past(bus_req.addr) == `TPT_ADDR_PUN_DATA && pun_char == $past(bus_req.wdata))
    else $error("punch start without its write");
  a_fault_refuses: assert property ((mech_in.pun_na || mech_in.pun_err) [*5]
      ##0 (bus_req.wr && bus_req.addr == `TPT_ADDR_PUN_DATA) |=> !pun_start)
    else $error("punch started while faulted");
  a_rdr_clear: assert property (bus_req.rd && bus_req.addr == `TPT_ADDR_RDR_STATUS
      && rdr_irq |-> ##2 !rdr_irq)
    else $error("reader request not cleared");
  a_pun_clear: assert property (bus_req.rd && bus_req.addr == `TPT_ADDR_PUN_STATUS
      && pun_irq |-> ##2 !pun_irq)
    else $error("punch request not cleared");
endmodule
bind tpt_ifc tpt_ifc_sva chk_u (.sys_clk, .nrst, .bus_req, .bus_rdata, .bus_rvalid,
  .mech_in, .rdr_advance, .pun_start, .pun_char, .rdr_irq, .pun_irq);
`default_nettype wire

// [tpt_mech_model.sv]
// behavioural reader and punch mechanisms facing the interface pins
`timescale 1ns/1ps
`default_nettype none
module tpt_mech_model (
  input wire logic sys_clk,
  input wire logic rdr_advance,
  input wire logic pun_start,
  input wire logic [7:0] next_char,
  input wire logic slow,
  output logic [7:0] rdr_char,
  output logic rdr_strobe,
  output logic pun_end
);
  logic [7:0] held; // character under the read head
  // reader: one character per advance; an advance while busy is lost
  initial begin
    rdr_char = 8'h00;
    rdr_strobe = 1'b0;
    forever begin
      @(posedge sys_clk);
      if (rdr_advance === 1'b1) begin
        held = next_char;
        repeat (slow ? 30 : 6) @(posedge sys_clk);
        #1 rdr_char = held;
        repeat (3) @(posedge sys_clk);
        #1 rdr_strobe = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 rdr_strobe = 1'b0;
        repeat (3) @(posedge sys_clk);
        // hold time over: inverted so a late capture cannot pass
        #1 rdr_char = ~held;
      end
    end
  end
  // punch: cycle length of 10 cycles, or 40 when slow, end marked by a level pulse
  initial begin
    pun_end = 1'b0;
    forever begin
      @(posedge sys_clk);
      if (pun_start === 1'b1) begin
        repeat (slow ? 40 : 10) @(posedge sys_clk);
        #1 pun_end = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 pun_end = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [tpt_ifc_tb_top.sv]
// self-checking bench for the tape reader, punch and tick interfaces
`timescale 1ns/1ps
`default_nettype none
`include "tpt_params.svh"
module tpt_ifc_tb_top;
  localparam int PER [4] = '{20, 16, 12, 8}; // tick period per rate code, shortened
  logic sys_clk;
  logic nrst;
  tpt_pkg::tpt_bus_req_t req; // bus request driven by the tasks
  tpt_pkg::tpt_mech_in_t mech; // pins gathered from model and bench
  logic [7:0] rdata, pchar, ivec, mchar, next_char, d;
  logic rvalid, adv, pstart, rirq, pirq, tirq, iany, mstrobe, mend;
  logic load_sw, pun_na, pun_err, pun_lp, slow;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  int n_adv = 0;
  int n_start = 0;
  int t1, t2, a, k;
  assign mech = {mchar, mstrobe, load_sw, mend, pun_na, pun_err, pun_lp};
  tpt_ifc #(.CYC_1000(8), .CYC_200(12), .CYC_100(16), .CYC_20(20)) dut_u (
    .sys_clk(sys_clk), .nrst(nrst), .bus_req(req), .bus_rdata(rdata), .bus_rvalid(rvalid),
    .mech_in(mech), .rdr_advance(adv), .pun_start(pstart), .pun_char(pchar),
    .rdr_irq(rirq), .pun_irq(pirq), .tick_irq(tirq), .irq_any(iany), .irq_vector(ivec));
  tpt_mech_model mdl_u (.sys_clk(sys_clk), .rdr_advance(adv), .pun_start(pstart),
    .next_char(next_char), .slow(slow), .rdr_char(mchar), .rdr_strobe(mstrobe),
    .pun_end(mend));
  // 50 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // cycle count, pulse counters and the hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (adv === 1'b1) n_adv <= n_adv + 1;
    if (pstart === 1'b1) n_start <= n_start + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (n_mismatch == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one-cycle strobes; an idle cycle always separates two accesses
  task automatic bus_rd(input logic [15:0] ad, output logic [7:0] v);
    @(posedge sys_clk);
    #1 req.rd = 1'b1;
    req.addr = ad;
    @(posedge sys_clk);
    #1 req.rd = 1'b0;
    chk("bus_rvalid", 8'h01, {7'h00, rvalid});
    v = rdata;
  endtask
  task automatic bus_wr(input logic [15:0] ad, input logic [7:0] v);
    @(posedge sys_clk);
    #1 req.wr = 1'b1;
    req.addr = ad;
    req.wdata = v;
    @(posedge sys_clk);
    #1 req.wr = 1'b0;
  endtask
  task automatic rdc(input string what, input logic [15:0] ad, input logic [7:0] exp,
      input logic [7:0] m = 8'hff);
    logic [7:0] v;
    bus_rd(ad, v);
    chk(what, exp & m, v & m);
  endtask
  // waits for a request line (0 reader, 1 punch, 2 tick), then one cycle more
  task automatic wait_irq(input int w);
    int i;
    logic s;
    for (i = 0; i < 400; i++) begin
      @(posedge sys_clk);
      #1 s = (w == 0) ? rirq : (w == 1) ? pirq : tirq;
      if (s === 1'b1) break;
    end
    if (i == 400) n_mismatch++;
    @(posedge sys_clk);
    #1;
  endtask
  // consume one character and start the next fetch
  task automatic fetch(input logic [7:0] exp, input logic [7:0] nxt);
    wait_irq(0);
    rdc("reader_status", `TPT_ADDR_RDR_STATUS, 8'hc0);
    next_char = nxt;
    rdc("reader_data", `TPT_ADDR_RDR_DATA, exp);
  endtask
  initial begin
    req = '0;
    nrst = 1'b0;
    {load_sw, pun_na, pun_err, pun_lp, slow} = 5'h00;
    next_char = 8'h5a;
    repeat (12) @(posedge sys_clk);
    #1 nrst = 1'b1;
    rdc("tick_status", `TPT_ADDR_TICK_STATUS, 8'h00);
    rdc("reader_status", `TPT_ADDR_RDR_STATUS, 8'h00);
    rdc("punch_status", `TPT_ADDR_PUN_STATUS, 8'h80);
    rdc("unmapped", 16'hffe0, 8'h00);
    bus_wr(`TPT_ADDR_RDR_STATUS, 8'h40);
    bus_rd(`TPT_ADDR_RDR_DATA, d);
    rdc("reader_status", `TPT_ADDR_RDR_STATUS, 8'h40);
    wait_irq(0);
    chk("irq_vector", 8'he8, ivec);
    fetch(8'h5a, 8'ha5);
    chk("rdr_irq", 8'h00, {7'h00, rirq});
    slow = 1'b1;
    fetch(8'ha5, 8'hc3);
    slow = 1'b0;
    wait_irq(0);
    rdc("reader_status", `TPT_ADDR_RDR_STATUS, 8'hc0);
    load_sw = 1'b1;
    wait_irq(0);
    rdc("reader_status", `TPT_ADDR_RDR_STATUS, 8'h41);
    a = n_adv;
    bus_rd(`TPT_ADDR_RDR_DATA, d);
    repeat (20) @(posedge sys_clk);
    #1 chk("advance_count", 8'(a), 8'(n_adv));
    rdc("reader_status", `TPT_ADDR_RDR_STATUS, 8'h41);
    next_char = 8'h7e;
    load_sw = 1'b0;
    wait_irq(0);
    rdc("reader_status", `TPT_ADDR_RDR_STATUS, 8'hc0);
    bus_wr(`TPT_ADDR_RDR_STATUS, 8'h00);
    rdc("reader_data", `TPT_ADDR_RDR_DATA, 8'h7e);
    repeat (30) @(posedge sys_clk);
    #1 chk("rdr_irq", 8'h00, {7'h00, rirq});
    rdc("reader_status", `TPT_ADDR_RDR_STATUS, 8'h80);
    bus_wr(`TPT_ADDR_PUN_STATUS, 8'h40);
    rdc("punch_status", `TPT_ADDR_PUN_STATUS, 8'hc0);
    a = n_start;
    bus_wr(`TPT_ADDR_PUN_DATA, 8'h96);
    chk("pun_start", 8'h01, {7'h00, pstart});
    bus_wr(`TPT_ADDR_PUN_DATA, 8'h11);
    chk("pun_char", 8'h96, pchar);
    rdc("punch_status", `TPT_ADDR_PUN_STATUS, 8'h40);
    wait_irq(1);
    chk("irq_vector", 8'hf0, ivec);
    rdc("punch_status", `TPT_ADDR_PUN_STATUS, 8'hc0);
    chk("start_count", 8'(a + 1), 8'(n_start));
    // unit not available, error, then run/load in load
    for (k = 0; k < 3; k++) begin
      {pun_lp, pun_err, pun_na} = 3'(1 << k);
      repeat (6) @(posedge sys_clk);
      wait_irq(1);
      rdc("punch_status", `TPT_ADDR_PUN_STATUS, (k == 0) ? 8'h01 : 8'h02, 8'h03);
      bus_wr(`TPT_ADDR_PUN_DATA, 8'h22);
      chk("pun_start", 8'h00, {7'h00, pstart});
      {pun_lp, pun_err, pun_na} = 3'h0;
      bus_rd(`TPT_ADDR_PUN_STATUS, d);
    end
    chk("pun_char", 8'h96, pchar);
    // every tick rate: period measured between two requests
    for (k = 0; k < 4; k++) begin
      bus_wr(`TPT_ADDR_TICK_STATUS, {5'h08, k[1:0], 1'b0});
      wait_irq(2);
      t1 = cyc;
      chk("irq_vector", 8'hec, ivec);
      chk("irq_any", 8'h01, {7'h00, iany});
      rdc("tick_status", `TPT_ADDR_TICK_STATUS, {5'h18, k[1:0], 1'b0});
      @(posedge sys_clk);
      #1 chk("tick_irq", 8'h00, {7'h00, tirq});
      wait_irq(2);
      t2 = cyc;
      chk("tick_period", 8'(PER[k]), 8'(t2 - t1));
      // drop the pending tick so the next rate starts from a clean request
      bus_rd(`TPT_ADDR_TICK_STATUS, d);
    end
    bus_wr(`TPT_ADDR_TICK_STATUS, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
